//--- core/sosd_pkg.sv
// Purpose: shared constants and carrier types for the output sequencer
// Assumes: 25 MHz system clock, conditioned signals arrive as 13-bit codes
// Notes:   output codes are DAC words for the two analog output stages
package sosd_pkg;

    // signal widths
    localparam int SOSD_DW       = 13;             // conditioned value width
    localparam int SOSD_CW       = 16;             // slot/waveform counter width

    // diagnostic fault band output codes
    localparam logic [12:0] SOSD_FB_LOW  = 13'h0080; // low fault band code
    localparam logic [12:0] SOSD_FB_HIGH = 13'h1f80; // high fault band code

    // power-on diagnostic waveform
    localparam int POWERON_STEP_US   = 1000;       // time per waveform step
    localparam int CLK_MHZ           = 25;
    localparam int POWERON_STEP_CYC  = POWERON_STEP_US * CLK_MHZ; // 25000 cycles

    // default sequential slot duration
    localparam int SEQ_SLOT_US       = 2000;
    localparam int SEQ_SLOT_CYC      = SEQ_SLOT_US * CLK_MHZ; // 50000 cycles

    // low-pass filter shift
    localparam logic [3:0] SOSD_LP_SHIFT = 4'h3;   // first-order iir, alpha 1/8

    // reset values
    localparam logic [12:0] SOSD_OUT_RST = 13'h0000;

    // secondary output source selection
    typedef enum logic [1:0]
    {
        SRC_TEMP   = 2'b00,
        SRC_HALF   = 2'b01,
        SRC_BRFUNC = 2'b10,
        SRC_SEQ    = 2'b11
    } sosd_src_t;

    // sequential mode slots
    typedef enum logic [1:0]
    {
        SLOT_LOW   = 2'b00,
        SLOT_HIGH  = 2'b01,
        SLOT_SEC   = 2'b10,
        SLOT_BR    = 2'b11
    } sosd_slot_t;

    // output phase
    typedef enum logic [1:0]
    {
        PH_POWERON = 2'b00,
        PH_NORMAL  = 2'b01,
        PH_DIAG    = 2'b10
    } sosd_phase_t;

    // conditioned input signals
    typedef struct packed
    {
        logic [12:0] bridge;   // conditioned bridge signal
        logic [12:0] brFunc;   // function of bridge signal
        logic [12:0] temp;     // conditioned temperature
        logic [12:0] half;     // conditioned half-bridge
    } sosd_sig_t;

    // failure monitor flags
    typedef struct packed
    {
        logic bridgeAging;
        logic bridgeConn;
        logic bridgeShort;
        logic tempSensor;
        logic feSelfTest;
        logic feOverdrive;
        logic oscFail;
        logic watchdog;
        logic arithCheck;
        logic nvmSig;
        logic romSig;
        logic ramParity;
        logic regParity;
        logic supplyLoss;
        logic groundLoss;
        logic brokenChip;
    } sosd_mon_t;

    // configuration
    typedef struct packed
    {
        sosd_src_t   src2;      // secondary output source
        logic        seqUseHalf;// sequential second value: half instead of temp
        logic        lp1En;     // primary low-pass enable
        logic        lp2En;     // secondary low-pass enable
        logic        pwrOnEn;   // power-on waveform enable
        logic [15:0] slotCyc;   // sequential slot duration in cycles
    } sosd_cfg_t;

endpackage : sosd_pkg

//--- core/sosd_output_seq.sv
// Purpose: output selection, sequencing, filtering and fault band forcing
// Assumes: monitors, serial ports and analog stages live outside this block
// Notes:   all outputs are registered; diagnostic state is left only by reset
`timescale 1ns/10ps

// Contract
// - primary output carries bridge signal in normal operation
// - secondary output selects one of four sources
// - sequence starts with low then high band
// - third slot carries temperature or half-bridge
// - last slot carries bridge function
// - each output has optional low-pass filter
// - outputs emit power-on diagnostic waveform
// - serial port reads 13-bit conditioned values
// - serial ports access configuration and calibration
// - one-wire link runs over primary pin
// - any failure forces both outputs to band
// - open select pin gives low band
// - select pin grounded gives high band
// - sensor monitors raise failure
// - front-end self-test and overdrive raise failure
// - oscillator, watchdog, arithmetic checks raise failure
// - memory signatures and parity raise failure
// - supply, ground, broken chip raise failure
module sosd_output_seq
    import sosd_pkg::*;
#(
    parameter int PWRON_CYC = POWERON_STEP_CYC      // cycles per waveform step
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // conditioned signals and configuration
    input  wire sosd_sig_t   sig,
    input  wire sosd_cfg_t   cfg,
    // failure monitors
    input  wire sosd_mon_t   mon,
    // fault band select pin level, high when left open (pull-up)
    input  wire logic        faultBandSelectPin,
    // one-wire link traffic on the primary pin
    input  wire logic        oneWireActive,
    // serial readout request
    input  wire logic        rdReq,
    input  wire logic [1:0]  rdSel,
    // output codes
    output logic [12:0]      primaryOutput,
    output logic [12:0]      secondaryOutput,
    output logic             primaryOutputEn_b,
    // serial readout answer
    output logic [12:0]      rdData,
    output logic             rdValid,
    // status
    output logic             diagnosticState,
    output sosd_slot_t       seqSlot
);

    // whole block state
    typedef struct packed
    {
        sosd_phase_t phase;     // power-on, normal or diagnostic
        logic        bandHigh;  // latched fault band choice
        sosd_slot_t  slot;      // current sequential slot
        logic [15:0] slotCnt;   // cycles into slot
        logic [15:0] pwrCnt;    // cycles into waveform step
        logic [1:0]  pwrStep;   // waveform step index
        logic [12:0] lp1;       // primary filter state
        logic [12:0] lp2;       // secondary filter state
        logic [12:0] out1;
        logic [12:0] out2;
        logic        out1En_b;
        logic [12:0] rd;
        logic        rdV;
        logic        diag;      // registered diagnostic flag
    } sosd_state_t;

    sosd_state_t st_r;          // registered state
    sosd_state_t st_nxt;        // next state

    logic        anyFail;       // any monitor reports failure
    logic [12:0] src2Val;       // selected secondary value before filtering
    logic [12:0] seq2nd;        // second measurement of the sequence

    // first-order low-pass: y += (x - y) >>> shift
    function automatic logic [12:0] lowPass(input logic [12:0] y, input logic [12:0] x);
        logic signed [13:0] diff;
        diff = $signed({1'b0, x}) - $signed({1'b0, y});
        lowPass = y + 13'(diff >>> SOSD_LP_SHIFT);
    endfunction : lowPass

    // fault band code for the latched pin choice
    function automatic logic [12:0] bandCode(input logic high);
        bandCode = high ? SOSD_FB_HIGH : SOSD_FB_LOW;
    endfunction : bandCode

    // failure collection: each monitor group is a plain flag
    always_comb
    begin
        anyFail = (mon.bridgeAging | mon.bridgeConn | mon.bridgeShort | mon.tempSensor)
                | (mon.feSelfTest | mon.feOverdrive)
                | (mon.oscFail | mon.watchdog | mon.arithCheck)
                | (mon.nvmSig | mon.romSig | mon.ramParity | mon.regParity)
                | (mon.supplyLoss | mon.groundLoss | mon.brokenChip);
    end

    // secondary source selection
    always_comb
    begin
        seq2nd = cfg.seqUseHalf ? sig.half : sig.temp;
        case (cfg.src2)
            SRC_TEMP:   src2Val = sig.temp;
            SRC_HALF:   src2Val = sig.half;
            SRC_BRFUNC: src2Val = sig.brFunc;
            SRC_SEQ:
            begin
                case (st_r.slot)
                    SLOT_LOW:  src2Val = SOSD_FB_LOW;
                    SLOT_HIGH: src2Val = SOSD_FB_HIGH;
                    SLOT_SEC:  src2Val = seq2nd;
                    SLOT_BR:   src2Val = sig.brFunc;
                    default:   src2Val = SOSD_FB_LOW;
                endcase
            end
            default:    src2Val = sig.temp;
        endcase
    end

    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rdV = 1'b0;
        // serial readout of 13-bit conditioned values in normal operation
        if (rdReq && st_r.phase == PH_NORMAL)
        begin
            st_nxt.rdV = 1'b1;
            case (rdSel)
                2'b00:   st_nxt.rd = sig.bridge;
                2'b01:   st_nxt.rd = sig.temp;
                2'b10:   st_nxt.rd = sig.half;
                default: st_nxt.rd = sig.brFunc;
            endcase
        end
        // primary pin released while the one-wire link talks over it
        st_nxt.out1En_b = oneWireActive;
        // filters track continuously so switching is glitch free
        st_nxt.lp1 = lowPass(st_r.lp1, sig.bridge);
        st_nxt.lp2 = lowPass(st_r.lp2, src2Val);
        // sequential slot timing; a zero duration is treated as one cycle
        if (st_r.slotCnt + 16'h0001 >= cfg.slotCyc)
        begin
            st_nxt.slotCnt = 16'h0000;
            st_nxt.slot    = sosd_slot_t'(st_r.slot + 2'b01); // wraps to low band
        end
        else
        begin
            st_nxt.slotCnt = st_r.slotCnt + 16'h0001;
        end
        if (cfg.src2 != SRC_SEQ)
        begin
            // restart the cycle so entering sequential mode begins with low band
            st_nxt.slot    = SLOT_LOW;
            st_nxt.slotCnt = 16'h0000;
        end
        case (st_r.phase)
            PH_POWERON:
            begin
                // stepped waveform: low band, high band, low band, then normal
                st_nxt.out1 = st_r.pwrStep[0] ? SOSD_FB_HIGH : SOSD_FB_LOW;
                st_nxt.out2 = st_nxt.out1;
                if (st_r.pwrCnt == 16'(PWRON_CYC - 1))
                begin
                    st_nxt.pwrCnt  = 16'h0000;
                    st_nxt.pwrStep = st_r.pwrStep + 2'b01;
                    if (st_r.pwrStep == 2'b10)
                        st_nxt.phase = PH_NORMAL;
                end
                else
                begin
                    st_nxt.pwrCnt = st_r.pwrCnt + 16'h0001;
                end
                if (!cfg.pwrOnEn)
                    st_nxt.phase = PH_NORMAL;
                if (anyFail)
                    st_nxt.phase = PH_DIAG;
            end
            PH_NORMAL:
            begin
                st_nxt.out1 = cfg.lp1En ? st_nxt.lp1 : sig.bridge;
                // fault band slots bypass the filter so the marks stay exact
                st_nxt.out2 = (cfg.lp2En && !(cfg.src2 == SRC_SEQ && !st_r.slot[1]))
                            ? st_nxt.lp2 : src2Val;
                if (anyFail)
                    st_nxt.phase = PH_DIAG;
            end
            PH_DIAG:
            begin
                // sticky until reset, both outputs at the selected band
                st_nxt.out1 = bandCode(st_r.bandHigh);
                st_nxt.out2 = bandCode(st_r.bandHigh);
                st_nxt.rdV  = 1'b0;
            end
            default:
            begin
                st_nxt.phase = PH_DIAG;
            end
        endcase
        // pin is sampled every cycle up to failure, then frozen
        if (st_r.phase != PH_DIAG)
            st_nxt.bandHigh = !faultBandSelectPin;
        // failure seen this cycle drives the band on the very next edge
        if (anyFail && st_r.phase != PH_DIAG)
        begin
            st_nxt.out1 = bandCode(!faultBandSelectPin);
            st_nxt.out2 = bandCode(!faultBandSelectPin);
        end
        // status kept in a flop so the pin has no decode behind it
        st_nxt.diag = (st_nxt.phase == PH_DIAG);
    end

    // state register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r          <= '0;
            st_r.phase    <= PH_POWERON;
            st_r.out1     <= SOSD_OUT_RST;
            st_r.out2     <= SOSD_OUT_RST;
            st_r.out1En_b <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the register
    assign primaryOutput     = st_r.out1;
    assign secondaryOutput   = st_r.out2;
    assign primaryOutputEn_b = st_r.out1En_b;
    assign rdData            = st_r.rd;
    assign rdValid           = st_r.rdV;
    assign diagnosticState   = st_r.diag;
    assign seqSlot           = st_r.slot;

    // assertions
    property p_diagEnter;
        @(posedge clk) disable iff (!rst_b)
        anyFail |=> diagnosticState;
    endproperty
    a_diagEnter: assert property (p_diagEnter) else $error("failure did not enter diagnostic state");

    property p_diagSticky;
        @(posedge clk) disable iff (!rst_b)
        diagnosticState |=> diagnosticState;
    endproperty
    a_diagSticky: assert property (p_diagSticky) else $error("diagnostic state left without reset");

    property p_bandLow;
        @(posedge clk) disable iff (!rst_b)
        (anyFail && !diagnosticState && faultBandSelectPin)
            |=> (primaryOutput == SOSD_FB_LOW && secondaryOutput == SOSD_FB_LOW) [*3];
    endproperty
    a_bandLow: assert property (p_bandLow) else $error("open select pin did not give low band");

    property p_bandHigh;
        @(posedge clk) disable iff (!rst_b)
        (anyFail && !diagnosticState && !faultBandSelectPin)
            |=> (primaryOutput == SOSD_FB_HIGH && secondaryOutput == SOSD_FB_HIGH) [*3];
    endproperty
    a_bandHigh: assert property (p_bandHigh) else $error("grounded select pin did not give high band");

    property p_primaryBridge;
        @(posedge clk) disable iff (!rst_b)
        (diagnosticState == 1'b0 && st_r.phase == PH_NORMAL && !anyFail && !cfg.lp1En)
            |=> primaryOutput == $past(sig.bridge);
    endproperty
    a_primaryBridge: assert property (p_primaryBridge) else $error("primary output not bridge signal");

    property p_seqOrder;
        @(posedge clk) disable iff (!rst_b)
        (cfg.src2 == SRC_SEQ && $past(cfg.src2) == SRC_SEQ && $changed(seqSlot))
            |-> seqSlot == sosd_slot_t'($past(seqSlot) + 2'b01);
    endproperty
    a_seqOrder: assert property (p_seqOrder) else $error("sequence slot out of order");

    property p_seqMarks;
        @(posedge clk) disable iff (!rst_b)
        (st_r.phase == PH_NORMAL && !anyFail && cfg.src2 == SRC_SEQ && seqSlot == SLOT_HIGH)
            |=> secondaryOutput == SOSD_FB_HIGH;
    endproperty
    a_seqMarks: assert property (p_seqMarks) else $error("high band mark missing in sequence");

    property p_seqBridge;
        @(posedge clk) disable iff (!rst_b)
        (st_r.phase == PH_NORMAL && !anyFail && cfg.src2 == SRC_SEQ && !cfg.lp2En && seqSlot == SLOT_BR)
            |=> secondaryOutput == $past(sig.brFunc);
    endproperty
    a_seqBridge: assert property (p_seqBridge) else $error("last slot not bridge function");

    property p_rdNormal;
        @(posedge clk) disable iff (!rst_b)
        rdValid |-> $past(st_r.phase) == PH_NORMAL;
    endproperty
    a_rdNormal: assert property (p_rdNormal) else $error("readout outside normal operation");

    property p_seqLow;
        @(posedge clk) disable iff (!rst_b)
        (st_r.phase == PH_NORMAL && !anyFail && cfg.src2 == SRC_SEQ && seqSlot == SLOT_LOW)
            |=> secondaryOutput == SOSD_FB_LOW;
    endproperty
    a_seqLow: assert property (p_seqLow) else $error("low band mark missing in sequence");

    property p_seqSecond;
        @(posedge clk) disable iff (!rst_b)
        (st_r.phase == PH_NORMAL && !anyFail && cfg.src2 == SRC_SEQ && !cfg.lp2En && seqSlot == SLOT_SEC)
            |=> secondaryOutput == ($past(cfg.seqUseHalf) ? $past(sig.half) : $past(sig.temp));
    endproperty
    a_seqSecond: assert property (p_seqSecond) else $error("second value slot wrong");

    property p_fixedSource;
        @(posedge clk) disable iff (!rst_b)
        (st_r.phase == PH_NORMAL && !anyFail && cfg.src2 != SRC_SEQ && !cfg.lp2En)
            |=> secondaryOutput == (($past(cfg.src2) == SRC_TEMP) ? $past(sig.temp)
                                  : ($past(cfg.src2) == SRC_HALF) ? $past(sig.half) : $past(sig.brFunc));
    endproperty
    a_fixedSource: assert property (p_fixedSource) else $error("secondary source not routed");

    property p_oneWireRelease;
        @(posedge clk) disable iff (!rst_b)
        oneWireActive |=> primaryOutputEn_b;
    endproperty
    a_oneWireRelease: assert property (p_oneWireRelease) else $error("primary stage not released");

    property p_powerOnBand;
        @(posedge clk) disable iff (!rst_b)
        (st_r.phase == PH_POWERON && !anyFail)
            |=> (primaryOutput == secondaryOutput
                 && (primaryOutput == SOSD_FB_LOW || primaryOutput == SOSD_FB_HIGH));
    endproperty
    a_powerOnBand: assert property (p_powerOnBand) else $error("power-on waveform off band levels");

    c_diag:   cover property (@(posedge clk) disable iff (!rst_b) $rose(diagnosticState));
    c_seqWrap: cover property (@(posedge clk) disable iff (!rst_b) seqSlot == SLOT_BR ##1 seqSlot == SLOT_LOW);
    c_normal: cover property (@(posedge clk) disable iff (!rst_b) st_r.phase == PH_POWERON ##1 st_r.phase == PH_NORMAL);
    c_read:   cover property (@(posedge clk) disable iff (!rst_b) rdValid);

endmodule : sosd_output_seq

//--- bench/sosd_ecu_model.sv
// Purpose: far side of the outputs: fault band strap and end-of-line tester
// Assumes: strap pin has a pull-up inside the device, so open reads high
// Notes:   tester traffic follows calReq directly; the protocol itself is not modelled
`timescale 1ns/10ps
module sosd_ecu_model
    import sosd_pkg::*;
(
    // bench controls
    input  wire logic pinGrounded,
    input  wire logic calReq,
    // lines towards the device
    output logic      faultBandSelectPin,
    output logic      oneWireActive
);
    // strap: open pin pulled up, grounded pin reads low
    assign faultBandSelectPin = pinGrounded ? 1'b0 : 1'b1;
    // tester talks on the primary pin only while asked to
    assign oneWireActive      = calReq;
endmodule : sosd_ecu_model

//--- bench/sensor_output_sequencer_diag_bench.sv
// Purpose: self-checking bench for the output sequencer
// Assumes: power-on step shortened to 4 cycles, slot length 3 cycles
// Notes:   inputs change on the falling edge, outputs judged there too
`timescale 1ns/10ps
module sensor_output_sequencer_diag_bench;
    import sosd_pkg::*;
    localparam int PW = 4;               // short power-on step keeps run brief
    logic        clk;                    // 25 MHz clock
    logic        rst_b;                  // async reset
    sosd_sig_t   sig;                    // conditioned signals
    sosd_cfg_t   cfg;                    // configuration
    sosd_mon_t   mon;                    // failure flags
    logic        faultBandSelectPin;     // strap level
    logic        oneWireActive;          // tester traffic
    logic        rdReq;                  // readout request
    logic [1:0]  rdSel;                  // readout select
    logic [12:0] primaryOutput;          // primary code
    logic [12:0] secondaryOutput;        // secondary code
    logic        primaryOutputEn_b;      // primary stage enable
    logic [12:0] rdData;                 // readout data
    logic        rdValid;                // readout strobe
    logic        diagnosticState;        // diagnostic flag
    sosd_slot_t  seqSlot;                // sequence slot
    logic        pinGrounded;            // strap wiring
    logic        calReq;                 // tester request
    int          fails;                  // mismatches
    int          num_checks;             // comparisons
    // device under test
    sosd_output_seq #(.PWRON_CYC(PW)) sosd_output_seq_i (.clk(clk), .rst_b(rst_b), .sig(sig), .cfg(cfg),
        .mon(mon), .faultBandSelectPin(faultBandSelectPin), .oneWireActive(oneWireActive), .rdReq(rdReq),
        .rdSel(rdSel), .primaryOutput(primaryOutput), .secondaryOutput(secondaryOutput),
        .primaryOutputEn_b(primaryOutputEn_b), .rdData(rdData), .rdValid(rdValid),
        .diagnosticState(diagnosticState), .seqSlot(seqSlot));
    // control unit and strap
    sosd_ecu_model sosd_ecu_model_i (.pinGrounded(pinGrounded), .calReq(calReq),
        .faultBandSelectPin(faultBandSelectPin), .oneWireActive(oneWireActive));
    // clock
    initial clk = 1'b0;
    always #20 clk = ~clk;
    // compare helper; an unknown never passes
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    // wait falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // verdict, also reached by the watchdog
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // reset for 20 cycles, judge values held in reset
    task automatic do_reset;
        rst_b = 1'b0;
        cyc(20);
        check(primaryOutput === SOSD_OUT_RST && secondaryOutput === SOSD_OUT_RST && rdValid === 1'b0
              && diagnosticState === 1'b0 && seqSlot === SLOT_LOW && primaryOutputEn_b === 1'b0, "reset values");
        rst_b = 1'b1;
    endtask : do_reset
    // power-on waveform low, high, low then live values; sampled mid-step
    task automatic t_poweron;
        cfg.pwrOnEn = 1'b1;
        do_reset();
        cyc(2);
        check(primaryOutput === SOSD_FB_LOW && secondaryOutput === SOSD_FB_LOW, "power-on step 1");
        rdReq = 1'b1;
        cyc(1);
        rdReq = 1'b0;
        check(rdValid === 1'b0, "readout refused in power-on");
        cyc(PW - 1);
        check(primaryOutput === SOSD_FB_HIGH && secondaryOutput === SOSD_FB_HIGH, "power-on step 2");
        cyc(PW);
        check(primaryOutput === SOSD_FB_LOW && secondaryOutput === SOSD_FB_LOW, "power-on step 3");
        cyc(PW + 2);
        check(primaryOutput === sig.bridge && secondaryOutput === sig.temp, "normal after power-on");
    endtask : t_poweron
    // fixed sources on the secondary and every readout select
    task automatic t_routes;
        logic [12:0] e;
        cfg.pwrOnEn = 1'b0;
        do_reset();
        cyc(3);
        for (int s = 0; s < 3; s++)
        begin
            cfg.src2 = sosd_src_t'(s);
            sig.bridge = 13'h0400 + 13'(s);
            cyc(2);
            e = (s == 0) ? sig.temp : (s == 1) ? sig.half : sig.brFunc;
            check(secondaryOutput === e, "secondary source");
            check(primaryOutput === sig.bridge, "primary follows bridge");
        end
        for (int r = 0; r < 4; r++)
        begin
            rdSel = 2'(r);
            rdReq = 1'b1;
            cyc(1);
            rdReq = 1'b0;
            e = (r == 0) ? sig.bridge : (r == 1) ? sig.temp : (r == 2) ? sig.half : sig.brFunc;
            check(rdValid === 1'b1 && rdData === e, "readout answer");
            cyc(1);
            check(rdValid === 1'b0 && rdData === e, "readout strobe one cycle");
        end
    endtask : t_routes
    // sequence order, slot length and contents
    task automatic t_seq(input logic useHalf);
        logic [1:0] prev;
        int         run;
        int         seen;
        prev = seqSlot;
        run = 0;
        seen = 0;
        cfg.slotCyc = 16'h0003;
        cfg.seqUseHalf = useHalf;
        cfg.src2 = SRC_SEQ;
        for (int i = 0; i < 60; i++)
        begin
            cyc(1);
            if (seqSlot !== prev)
            begin
                check(seqSlot === prev + 2'h1, "slot order");
                if (seen > 0)
                    check(run == 3, "slot length");
                seen++;
                run = 0;
                prev = seqSlot;
            end
            run++;
            if (run == 2 && seen > 0)
            begin
                case (prev)
                    2'h0: check(secondaryOutput === SOSD_FB_LOW, "sequence low band");
                    2'h1: check(secondaryOutput === SOSD_FB_HIGH, "sequence high band");
                    2'h2: check(secondaryOutput === (useHalf ? sig.half : sig.temp), "second value");
                    default: check(secondaryOutput === sig.brFunc, "bridge function slot");
                endcase
                check(primaryOutput === sig.bridge, "primary during sequence");
            end
        end
        check(seen >= 8, "sequence keeps running");
    endtask : t_seq
    // filters move gradually toward a step on both outputs
    task automatic t_filter;
        cfg.src2 = SRC_TEMP;
        sig.bridge = 13'h0400;
        sig.temp = 13'h0400;
        cfg.lp1En = 1'b1;
        cfg.lp2En = 1'b1;
        cyc(200);
        sig.bridge = 13'h0800;
        sig.temp = 13'h0800;
        cyc(3);
        check(primaryOutput > 13'h0400 && primaryOutput < 13'h0780, "primary filtered");
        check(secondaryOutput > 13'h0400 && secondaryOutput < 13'h0780, "secondary filtered");
        cyc(200);
        check(primaryOutput >= 13'h07f8 && primaryOutput <= 13'h0800, "primary settles");
        check(secondaryOutput >= 13'h07f8 && secondaryOutput <= 13'h0800, "secondary settles");
        cfg.lp1En = 1'b0;
        cfg.lp2En = 1'b0;
    endtask : t_filter
    // tester traffic releases the primary stage
    task automatic t_onewire;
        calReq = 1'b1;
        cyc(3);
        check(primaryOutputEn_b === 1'b1, "primary released");
        calReq = 1'b0;
        cyc(3);
        check(primaryOutputEn_b === 1'b0, "primary driven again");
    endtask : t_onewire
    // each monitor alone forces the band, strap alternates
    task automatic t_fail;
        logic [12:0] e;
        for (int b = 0; b < 16; b++)
        begin
            pinGrounded = b[0];
            do_reset();
            cyc(3);
            mon = sosd_mon_t'(16'h0001 << b);
            cyc(1);
            mon = '0;
            e = b[0] ? SOSD_FB_HIGH : SOSD_FB_LOW;
            check(diagnosticState === 1'b1 && primaryOutput === e && secondaryOutput === e, "band");
            pinGrounded = ~b[0];
            rdReq = 1'b1;
            cyc(1);
            rdReq = 1'b0;
            check(rdValid === 1'b0, "readout refused in diagnostic state");
            cyc(4);
            check(diagnosticState === 1'b1 && primaryOutput === e && secondaryOutput === e, "band held");
        end
    endtask : t_fail
    // main sequence
    initial
    begin
        fails = 0;
        num_checks = 0;
        rst_b = 1'b0;
        sig = '{bridge: 13'h0400, brFunc: 13'h1b00, temp: 13'h0a11, half: 13'h0c22};
        cfg = '{src2: SRC_TEMP, seqUseHalf: 1'b0, lp1En: 1'b0, lp2En: 1'b0, pwrOnEn: 1'b1, slotCyc: 16'h0003};
        mon = '0;
        pinGrounded = 1'b0;
        calReq = 1'b0;
        rdReq = 1'b0;
        rdSel = 2'h0;
        t_poweron();
        t_routes();
        t_seq(1'b0);
        t_seq(1'b1);
        t_filter();
        t_onewire();
        t_fail();
        stop_test();
    end
    // watchdog: roughly 1070 cycles expected, allow far more
    initial
    begin
        #400000;
        fails++;
        stop_test();
    end
endmodule : sensor_output_sequencer_diag_bench
